/* hw/ssb_pkg.sv */
// Behaviour
// - Read loaded in cycle n drives data in n+1; write takes data in n+1.
// - Advance high with hold low steps the burst counter and uses internal address.
// - Burst cycles ignore read/write select and keep the loaded direction.
// - Advance low with any select inactive starts a deselect cycle.
// - Bus goes high impedance the cycle after deselect; pending transfer completes first.
// - Clock hold high blocks the edge; transfer state and bus drive hold, test port registers still update.
// - Selected only when first and third selects low and second high.
// - Data outputs stay high impedance from power-up.
// - Low lane enable alone writes bits 0 to 7 and low parity; both high write nothing.
// - High lane enable alone writes bits 9 to 16 and high parity; both low write all.
// - Several byte lanes may be written in the same cycle.
// - Burst order select high gives interleaved order of the two low address bits.
// - Burst order select low steps the two low address bits linearly modulo four.
// - After the fourth address the counter wraps to start and keeps cycling.
// - Read data valid in the same cycle after clock-to-data delay, no extra register.
// - Undriven test inputs keep the test controller disabled from power-up.
// - Optional test reset is pulled high so leaving it unused never resets test logic.
`default_nettype none

package ssb_pkg;
  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 18;
  localparam int LANE_W     = 9;
  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic [1:0] CNT_RST   = 2'h0;
  typedef enum logic [1:0] {SSB_IDLE, SSB_READ, SSB_WRITE} ssb_op_t;
endpackage

`default_nettype wire

/* hw/ssb_fifo.sv */
`default_nettype none

module ssb_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } ssb_fifo_st_t;

  ssb_fifo_st_t     st_ff;
  ssb_fifo_st_t     nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic             push;
  logic             pop;

  // Handshakes
  assign in_ready_out  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st_ff.cnt != '0);
  assign out_data_out  = mem_ff[st_ff.rd];
  assign push          = ce_in && in_valid_in && in_ready_out;
  assign pop           = ce_in && out_valid_out && out_ready_in;

  // Pointer update
  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wr = st_ff.wr + 1'b1;
    if (pop) nxt_st.rd = st_ff.rd + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) mem_ff[st_ff.wr] <= in_data_in;
  end
endmodule

`default_nettype wire

/* hw/ssb_array.sv */
`default_nettype none

module ssb_array (
  // Clock
  input  wire logic                        clk_in,
  // Write port
  input  wire logic                        wr_en_in,
  input  wire logic [1:0]                  wr_lane_in,
  input  wire logic [ssb_pkg::ADDR_W-1:0]  wr_addr_in,
  input  wire logic [ssb_pkg::DATA_W-1:0]  wr_data_in,
  // Read port
  input  wire logic [ssb_pkg::ADDR_W-1:0]  rd_addr_in,
  output logic      [ssb_pkg::DATA_W-1:0]  rd_data_out
);
  // Small modelled depth, indexed by low address bits
  localparam int DEPTH = 256;
  logic [ssb_pkg::DATA_W-1:0] mem_ff [DEPTH];

  // Per-lane write
  always_ff @(posedge clk_in) begin
    if (wr_en_in && wr_lane_in[0])
      mem_ff[wr_addr_in[7:0]][8:0] <= wr_data_in[8:0];
    if (wr_en_in && wr_lane_in[1])
      mem_ff[wr_addr_in[7:0]][17:9] <= wr_data_in[17:9];
  end

  // Flow-through read
  assign rd_data_out = mem_ff[rd_addr_in[7:0]];
endmodule

`default_nettype wire

/* hw/ssb_ctrl.sv */
`default_nettype none

module ssb_ctrl (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        ce_in,
  // Memory controller side
  input  wire logic                        clock_hold_n_in,
  input  wire logic                        advance_or_load_in,
  input  wire logic                        rd_not_wr_in,
  input  wire logic                        chip_sel_first_n_in,
  input  wire logic                        chip_sel_second_in,
  input  wire logic                        chip_sel_third_n_in,
  input  wire logic                        lane_low_wr_n_in,
  input  wire logic                        lane_high_wr_n_in,
  input  wire logic                        burst_order_sel_in,
  input  wire logic [ssb_pkg::ADDR_W-1:0]  addr_in,
  // Data bus
  input  wire logic [ssb_pkg::DATA_W-1:0]  data_in,
  output logic      [ssb_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe_out,
  // Test port
  input  wire logic                        test_mode_in,
  input  wire logic                        test_data_in,
  input  wire logic                        test_clk_in,
  input  wire logic                        test_rst_n_in,
  output logic                             test_data_out,
  output logic                             test_data_oe_out,
  // Write log stream
  output logic                             log_valid_out,
  input  wire logic                        log_ready_in,
  output logic      [37:0]                 log_data_out
);
  typedef struct packed {
    ssb_pkg::ssb_op_t            op;
    logic [ssb_pkg::ADDR_W-1:0]  base;
    logic [1:0]                  start;
    logic [1:0]                  cnt;
    logic                        interleave;
    logic                        oe;
    logic [ssb_pkg::DATA_W-1:0]  dout;
    logic                        test_oe;
    logic                        test_dout;
  } ssb_st_t;

  ssb_st_t                     st_ff;
  ssb_st_t                     nxt_st;
  logic                        edge_ok;
  logic                        selected;
  logic                        load;
  logic                        burst;
  logic [ssb_pkg::ADDR_W-1:0]  cur_addr;
  logic [ssb_pkg::ADDR_W-1:0]  nxt_rd_addr;
  logic [ssb_pkg::DATA_W-1:0]  rd_word;
  logic [1:0]                  lanes;
  logic                        wr_now;
  logic                        fifo_ready;

  // ----------------------------------------
  // Burst order helper
  // ----------------------------------------
  function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt,
                                           input logic il);
    burst_low = il ? (start ^ cnt) : 2'(start + cnt);
  endfunction

  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  // clock hold blocks edge
  assign edge_ok  = ce_in && !clock_hold_n_in && fifo_ready;
  assign selected = !chip_sel_first_n_in && chip_sel_second_in && !chip_sel_third_n_in;
  assign load     = edge_ok && !advance_or_load_in && selected;
  assign burst    = edge_ok && advance_or_load_in;
  assign cur_addr = {st_ff.base[ssb_pkg::ADDR_W-1:2],
                     burst_low(st_ff.start, st_ff.cnt, st_ff.interleave)};
  assign lanes    = {!lane_high_wr_n_in, !lane_low_wr_n_in};
  // write data taken the cycle after load
  assign wr_now   = edge_ok && st_ff.op == ssb_pkg::SSB_WRITE;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_rd_addr = cur_addr;
    if (edge_ok) begin
      if (load) begin
        nxt_st.base = addr_in;
        nxt_st.start = addr_in[1:0];
        nxt_st.cnt = ssb_pkg::CNT_RST;
        nxt_st.interleave = burst_order_sel_in;
        nxt_st.op = rd_not_wr_in ? ssb_pkg::SSB_READ : ssb_pkg::SSB_WRITE;
        nxt_rd_addr = addr_in;
      end else if (burst) begin
        nxt_st.cnt = 2'(st_ff.cnt + ssb_pkg::BURST_ONE);
        nxt_st.op = st_ff.op;
        nxt_rd_addr = {st_ff.base[ssb_pkg::ADDR_W-1:2],
                       burst_low(st_ff.start, nxt_st.cnt, st_ff.interleave)};
      end else begin
        nxt_st.op = ssb_pkg::SSB_IDLE;
      end
      nxt_st.oe = nxt_st.op == ssb_pkg::SSB_READ;
      // next read word presented right after edge
      nxt_st.dout = rd_word;
    end
    // test output only driven when test mode active
    // test reset low holds it off
    nxt_st.test_oe = test_rst_n_in && test_mode_in && test_clk_in;
    // Registered test data path
    nxt_st.test_dout = test_data_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) st_ff <= '0;
    else if (ce_in) st_ff <= nxt_st;
  end

  // ----------------------------------------
  // Storage and log stream
  // ----------------------------------------
  ssb_array u_array (
    .clk_in      (clk_in),
    .wr_en_in    (wr_now),
    .wr_lane_in  (lanes),
    .wr_addr_in  (cur_addr),
    .wr_data_in  (data_in),
    .rd_addr_in  (nxt_rd_addr),
    .rd_data_out (rd_word)
  );

  ssb_fifo #(.WIDTH(38), .DEPTH(ssb_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .ce_in         (ce_in),
    .in_valid_in   (wr_now),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({cur_addr, data_in}),
    .out_valid_out (log_valid_out),
    .out_ready_in  (log_ready_in),
    .out_data_out  (log_data_out)
  );

  // Outputs
  assign data_out         = st_ff.dout;
  assign data_oe_out      = st_ff.oe;
  assign test_data_out    = st_ff.test_dout;
  assign test_data_oe_out = st_ff.test_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_hold_freeze: assert property (
    (!edge_ok && ce_in) |=> $stable(data_oe_out) && $stable(data_out))
    else $error("state moved under hold");
  chk_read_drive: assert property (
    (load && rd_not_wr_in) |=> data_oe_out)
    else $error("read not driven next cycle");
  chk_write_release: assert property (
    (load && !rd_not_wr_in) |=> !data_oe_out)
    else $error("bus driven during write");
  chk_deselect_hiz: assert property (
    (edge_ok && !advance_or_load_in && !selected) |=> !data_oe_out)
    else $error("bus not released after deselect");
  chk_noop_hiz: assert property (
    (edge_ok && advance_or_load_in && st_ff.op == ssb_pkg::SSB_IDLE) |=> !data_oe_out)
    else $error("bus driven on noop");
  chk_burst_dir: assert property (
    burst |=> st_ff.op == $past(st_ff.op))
    else $error("burst changed direction");
  chk_burst_step: assert property (
    burst |=> st_ff.cnt == 2'($past(st_ff.cnt) + 2'h1))
    else $error("counter not advanced");
  chk_load_base: assert property (
    load |=> st_ff.base == $past(addr_in) && st_ff.cnt == 2'h0)
    else $error("address not captured");
  chk_sel_needed: assert property (
    (edge_ok && !selected && !advance_or_load_in) |=> st_ff.op == ssb_pkg::SSB_IDLE)
    else $error("started while deselected");

  cov_load_read:   cover property (load && rd_not_wr_in ##1 burst);
  cov_load_write:  cover property (load && !rd_not_wr_in ##1 burst);
  cov_hold:        cover property (ce_in && clock_hold_n_in);
  cov_deselect:    cover property (edge_ok && !advance_or_load_in && !selected);
endmodule

`default_nettype wire

/* verification/ssb_host_model.sv */
`default_nettype none

module ssb_host_model (
  // Clock
  input  wire logic        clk_in,
  // Controller strobes
  output logic             clock_hold_n_out,
  output logic             advance_or_load_out,
  output logic             rd_not_wr_out,
  output logic             burst_order_sel_out,
  output logic [2:0]       chip_sel_out,
  output logic [1:0]       lane_wr_n_out,
  // Address and write data
  output logic [19:0]      addr_out,
  output logic [17:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: first select high so deselected, loading nothing yet
  initial begin
    {clock_hold_n_out, advance_or_load_out, rd_not_wr_out, burst_order_sel_out} = 4'h2;
    chip_sel_out  = 3'h3;
    lane_wr_n_out = 2'h3;
    addr_out      = 20'h00000;
    data_out      = 18'h15555;
  end

  // select code zero selects, others drop one select
  task automatic cyc(input logic hold, adv, rnw, ord, input logic [1:0] sel,
                     input logic [1:0] ln, input logic [19:0] a, input logic [17:0] d);
    @(posedge clk_in);
    clock_hold_n_out    <= hold;
    advance_or_load_out <= adv;
    rd_not_wr_out       <= rnw;
    burst_order_sel_out <= ord;
    chip_sel_out        <= 3'h2 ^ ((sel == 2'h0) ? 3'h0 : (3'h1 << (sel - 2'h1)));
    lane_wr_n_out       <= ln;
    addr_out            <= a;
    // Undriven data toggles so a stale value never matches
    data_out            <= $isunknown(d) ? ~data_out : d;
  endtask
endmodule

`default_nettype wire

/* verification/tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic L = 1'h0;
  localparam logic H = 1'h1;
  logic        clk_in    = 1'h0;
  logic        rst_b_in  = 1'h0;
  logic        ce        = 1'h1;
  logic        log_ready = 1'h1;
  logic        hold_n, adv, rnw, ord, d_oe, t_oe, t_do, l_vld;
  logic [2:0]  cs;
  logic [1:0]  ln;
  logic [19:0] a;
  logic [17:0] wd, rq;
  logic [37:0] l_dat;
  logic [17:0] mem [256];
  int          error_cnt  = 0;
  int          num_checks = 0;

  // Clock at 125 MHz
  always #4 clk_in = ~clk_in;

  ssb_host_model host (.clk_in(clk_in), .clock_hold_n_out(hold_n), .advance_or_load_out(adv),
    .rd_not_wr_out(rnw), .burst_order_sel_out(ord), .chip_sel_out(cs), .lane_wr_n_out(ln),
    .addr_out(a), .data_out(wd));

  ssb_ctrl DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .clock_hold_n_in(hold_n),
    .advance_or_load_in(adv), .rd_not_wr_in(rnw), .chip_sel_first_n_in(cs[0]),
    .chip_sel_second_in(cs[1]), .chip_sel_third_n_in(cs[2]), .lane_low_wr_n_in(ln[0]),
    .lane_high_wr_n_in(ln[1]), .burst_order_sel_in(ord), .addr_in(a), .data_in(wd),
    .data_out(rq), .data_oe_out(d_oe), .test_mode_in(L), .test_data_in(L), .test_clk_in(L),
    .test_rst_n_in(H), .test_data_out(t_do), .test_data_oe_out(t_oe), .log_valid_out(l_vld),
    .log_ready_in(log_ready), .log_data_out(l_dat));

  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [19:0] beat(input logic o, input logic [19:0] s, input int k);
    return {s[19:2], o ? (s[1:0] ^ k[1:0]) : (s[1:0] + k[1:0])};
  endfunction

  // Two idle cycles after a stop: bus released, then kept released
  task automatic idle_chk();
    host.cyc(L, H, H, L, 2'h0, 2'h3, 20'h0, 'x);
    @(negedge clk_in);
    chk(d_oe, 0);
    host.cyc(L, H, L, L, 2'h0, 2'h3, 20'h0, 'x);
    @(negedge clk_in);
    chk(d_oe, 0);
  endtask

  // Load write, data goes with the stop cycle
  task automatic wr(input logic [19:0] x, input logic [17:0] d, input logic [1:0] n);
    host.cyc(L, L, L, L, 2'h0, n, x, 'x);
    host.cyc(L, L, L, L, 2'h1, n, x, d);
    if (!n[0]) mem[x[7:0]][8:0] = d[8:0];
    if (!n[1]) mem[x[7:0]][17:9] = d[17:9];
  endtask

  // Single read, ended by a stop with the given select dropped
  task automatic rd(input logic [19:0] x, input logic [1:0] sel);
    host.cyc(L, L, H, L, 2'h0, 2'h3, x, 'x);
    host.cyc(L, L, H, L, sel, 2'h3, x, 'x);
    @(negedge clk_in);
    chk(rq, mem[x[7:0]]);
    chk(d_oe, 1);
    idle_chk();
  endtask

  // Linear burst write with the read select flipped on the bursts
  task automatic burst_wr(input logic [19:0] s);
    host.cyc(L, L, L, L, 2'h0, 2'h0, s, 'x);
    for (int k = 0; k < 4; k++) begin
      mem[beat(L, s, k) % 256] = 18'h2A000 + 18'(k);
      host.cyc(L, k != 3, H, L, {1'h0, k == 3}, 2'h0, s, 18'h2A000 + 18'(k));
    end
  endtask

  // Burst read of five beats with one held edge
  task automatic burst_rd(input logic o, input logic [19:0] s);
    host.cyc(L, L, H, o, 2'h0, 2'h3, s, 'x);
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        host.cyc(H, L, L, L, 2'h1, 2'h0, 20'h0, 'x);
        @(negedge clk_in);
        chk(rq, mem[beat(o, s, 2) % 256]);
      end
      host.cyc(L, k != 4, L, L, {1'h0, k == 4}, 2'h3, s, 'x);
      @(negedge clk_in);
      chk(rq, mem[beat(o, s, k) % 256]);
    end
    idle_chk();
  endtask

  // Fill the log until it refuses, then drain it
  task automatic log_fill();
    int n;
    logic [37:0] first;
    n = 0;
    log_ready <= L;
    for (int i = 0; i < 34; i++) wr(20'h00080 + 20'(i), 18'(i), 2'h0);
    @(posedge clk_in);
    log_ready <= H;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_in);
      if (l_vld && log_ready) begin
        if (n == 0) first = l_dat;
        n++;
      end
    end
    chk(38'(n), 38'd32);
    chk(first, {20'h00080, 18'h00000});
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    chk(d_oe, 0);
    chk(t_oe, 0);
    rst_b_in <= H;
    wr(20'h00040, 18'h3FFFF, 2'h0);
    rd(20'h00040, 2'h1);
    wr(20'h00040, 18'h00000, 2'h2);
    rd(20'h00040, 2'h2);
    wr(20'h00040, 18'h00000, 2'h1);
    rd(20'h00040, 2'h3);
    wr(20'h00040, 18'h3FFFF, 2'h3);
    rd(20'h00040, 2'h1);
    burst_wr(20'h00021);
    burst_rd(L, 20'h00021);
    burst_rd(H, 20'h00021);
    log_fill();
    chk(t_do, 0);
    chk(t_oe, 0);
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
endmodule

`default_nettype wire
